// ===== hw/msplc_cfg.svh
`ifndef MSPLC_CFG_SVH
`define MSPLC_CFG_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define MSPLC_OFS_LPC       8'h00
`define MSPLC_OFS_MSH       8'h04
`define MSPLC_OFS_MSL       8'h08
`define MSPLC_OFS_MSA       8'h0c

// ************************************************************
// Reset values
// ************************************************************
`define MSPLC_RST_LPC       8'h00
`define MSPLC_RST_MSH       8'h3f
`define MSPLC_RST_MSL       8'hff
`define MSPLC_RST_MSA       8'h00

// ************************************************************
// Field positions
// ************************************************************
`define MSPLC_LPC_SEL       5
`define MSPLC_LPC_EN        4
`define MSPLC_MSH_XFER      6
`define MSPLC_MSH_FRT       5
`define MSPLC_MSH_TMRA      4
`define MSPLC_MSH_PWM       3
`define MSPLC_MSH_ADC       1
`define MSPLC_MSH_TMRB      0
`define MSPLC_MSL_SER3      7
`define MSPLC_MSL_SER1      6
`define MSPLC_MSL_TW0       4
`define MSPLC_MSL_TW1       3
`define MSPLC_MSL_TW23      2
`define MSPLC_MSL_CRC       1
`define MSPLC_MSA_PWM1      2
`define MSPLC_MSA_PWM0      1

// ************************************************************
// Sampling divider terminal counts
// ************************************************************
`define MSPLC_DIV_SLOW      5'h1f
`define MSPLC_DIV_FAST      5'h03

`endif

// ===== hw/msplc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

`include "msplc_cfg.svh"

module msplc_ctrl (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire msplc_pkg::msplc_adr_t wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire msplc_pkg::msplc_word_t wb_dat_i,
  output msplc_pkg::msplc_word_t     wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  extSubclkPin,
  output logic                       subclkOut,
  output logic                       xferCtrlStop,
  output logic                       freeRunTimerStop,
  output logic                       timer8aStop,
  output logic                       pwmCh0Stop,
  output logic                       pwmCh1Stop,
  output logic                       adcStop,
  output logic                       timer8bStop,
  output logic                       serialIface3Stop,
  output logic                       serialIface1Stop,
  output logic                       twoWireCh0Stop,
  output logic                       twoWireCh1Stop,
  output logic                       twoWireCh23Stop,
  output logic                       crcStop
);
  import msplc_pkg::*;

  msplc_byte_t lpcR;
  msplc_byte_t mshR;
  msplc_byte_t mslR;
  msplc_byte_t msaR;
  logic        ack_r;
  msplc_word_t dat_r;
  logic        reqStart;
  logic        wrEn;
  msplc_reg_t  regSel;

  msplc_sub_if subIf ();

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic msplc_reg_t decodeReg(input msplc_adr_t adr);
    case (adr)
      `MSPLC_OFS_LPC: decodeReg = REG_LPC;
      `MSPLC_OFS_MSH: decodeReg = REG_MSH;
      `MSPLC_OFS_MSL: decodeReg = REG_MSL;
      `MSPLC_OFS_MSA: decodeReg = REG_MSA;
      default:        decodeReg = REG_NONE;
    endcase
  endfunction

  function automatic msplc_byte_t readReg(input msplc_reg_t sel,
                                          input msplc_byte_t l,
                                          input msplc_byte_t h,
                                          input msplc_byte_t lo,
                                          input msplc_byte_t a);
    case (sel)
      REG_LPC: readReg = l;
      REG_MSH: readReg = h;
      REG_MSL: readReg = lo;
      REG_MSA: readReg = a;
      default: readReg = 8'h00;
    endcase
  endfunction

  assign regSel   = decodeReg(wb_adr_i);
  assign reqStart = wb_cyc_i && wb_stb_i && !ack_r;
  assign wrEn     = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];

  // ************************************************************
  // Bus handshake
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= reqStart;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dat_r <= 32'h0000_0000;
    end else if (reqStart && !wb_we_i) begin
      dat_r <= {24'h00_0000, readReg(regSel, lpcR, mshR, mslR, msaR)};
    end else begin
      dat_r <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ************************************************************
  // Low-power control register
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lpcR <= `MSPLC_RST_LPC;
    end else if (wrEn && regSel == REG_LPC) begin
      lpcR <= wb_dat_i[7:0];
    end
  end

  // ************************************************************
  // Module-stop registers
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mshR <= `MSPLC_RST_MSH;
    end else if (wrEn && regSel == REG_MSH) begin
      mshR <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mslR <= `MSPLC_RST_MSL;
    end else if (wrEn && regSel == REG_MSL) begin
      mslR <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      msaR <= `MSPLC_RST_MSA;
    end else if (wrEn && regSel == REG_MSA) begin
      msaR <= wb_dat_i[7:0];
    end
  end

  // ************************************************************
  // Stop outputs
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      xferCtrlStop     <= 1'b0;
      freeRunTimerStop <= 1'b1;
      timer8aStop      <= 1'b1;
      pwmCh0Stop       <= 1'b1;
      pwmCh1Stop       <= 1'b1;
      adcStop          <= 1'b1;
      timer8bStop      <= 1'b1;
      serialIface3Stop <= 1'b1;
      serialIface1Stop <= 1'b1;
      twoWireCh0Stop   <= 1'b1;
      twoWireCh1Stop   <= 1'b1;
      twoWireCh23Stop  <= 1'b1;
      crcStop          <= 1'b1;
    end else begin
      xferCtrlStop     <= mshR[`MSPLC_MSH_XFER];
      freeRunTimerStop <= mshR[`MSPLC_MSH_FRT];
      timer8aStop      <= mshR[`MSPLC_MSH_TMRA];
      adcStop          <= mshR[`MSPLC_MSH_ADC];
      timer8bStop      <= mshR[`MSPLC_MSH_TMRB];
      serialIface3Stop <= mslR[`MSPLC_MSL_SER3];
      serialIface1Stop <= mslR[`MSPLC_MSL_SER1];
      twoWireCh0Stop   <= mslR[`MSPLC_MSL_TW0];
      twoWireCh1Stop   <= mslR[`MSPLC_MSL_TW1];
      twoWireCh23Stop  <= mslR[`MSPLC_MSL_TW23];
      crcStop          <= mslR[`MSPLC_MSL_CRC];
      // Shared bit overrides per-channel bits
      pwmCh0Stop <= mshR[`MSPLC_MSH_PWM] | msaR[`MSPLC_MSA_PWM0];
      pwmCh1Stop <= mshR[`MSPLC_MSH_PWM] | msaR[`MSPLC_MSA_PWM1];
    end
  end

  // ************************************************************
  // Subclock input path
  // ************************************************************
  assign subIf.sampleSel = lpcR[`MSPLC_LPC_SEL];
  assign subIf.inputEn   = lpcR[`MSPLC_LPC_EN];
  assign subIf.extPin    = extSubclkPin;
  assign subclkOut       = subIf.subclk;

  msplc_subclk_filter #(
    .FILT_LEN (3)
  ) u_filter (
    .mclk   (mclk),
    .arst_n (arst_n),
    .sub    (subIf.filt)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  ack_one_cycle_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    reqStart |=> ack_r ##1 !ack_r)
    else $error("ack not a single cycle after request");

  lpc_reset_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    !$past(arst_n) |-> lpcR == 8'h00)
    else $error("low-power register reset value wrong");

  msh_reset_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    !$past(arst_n) |-> mshR == 8'h3f)
    else $error("high stop register reset value wrong");

  msl_reset_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    !$past(arst_n) |-> mslR == 8'hff && crcStop && serialIface3Stop)
    else $error("low stop register reset value wrong");

  msa_reset_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    !$past(arst_n) |-> msaR == 8'h00 && pwmCh0Stop && pwmCh1Stop)
    else $error("aux stop register reset value wrong");

  xfer_stop_wr_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    (wrEn && regSel == REG_MSH) |=> ##1
      (xferCtrlStop == $past(wb_dat_i[6], 2)) &&
      (adcStop == $past(wb_dat_i[1], 2)))
    else $error("high stop output does not follow write");

  low_stop_map_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    (wrEn && regSel == REG_MSL) |=> ##1
      (twoWireCh1Stop == $past(wb_dat_i[3], 2)) &&
      (crcStop == $past(wb_dat_i[1], 2)))
    else $error("low stop output does not follow write");

  pwm_combine_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    $past(arst_n) |->
      (pwmCh1Stop == ($past(mshR[3]) | $past(msaR[2]))) &&
      (pwmCh0Stop == ($past(mshR[3]) | $past(msaR[1]))))
    else $error("PWM stop combination wrong");

  stop_hold_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    ($past(arst_n) && $changed(timer8aStop)) |-> $past(wrEn, 2))
    else $error("stop level changed without a write");

endmodule

`default_nettype wire

// ===== hw/msplc_pkg.sv
package msplc_pkg;

  typedef logic [7:0]  msplc_byte_t;
  typedef logic [31:0] msplc_word_t;
  typedef logic [7:0]  msplc_adr_t;

  typedef enum logic [2:0] {
    REG_LPC,
    REG_MSH,
    REG_MSL,
    REG_MSA,
    REG_NONE
  } msplc_reg_t;

endpackage

// ===== hw/msplc_sub_if.sv
`timescale 1ns/100ps
`default_nettype none

interface msplc_sub_if;
  logic sampleSel;
  logic inputEn;
  logic extPin;
  logic subclk;

  modport ctrl (
    output sampleSel,
    output inputEn,
    output extPin,
    input  subclk
  );

  modport filt (
    input  sampleSel,
    input  inputEn,
    input  extPin,
    output subclk
  );
endinterface

`default_nettype wire

// ===== hw/msplc_subclk_filter.sv
`timescale 1ns/100ps
`default_nettype none

`include "msplc_cfg.svh"

module msplc_subclk_filter #(
  parameter int FILT_LEN = 3
) (
  input wire logic mclk,
  input wire logic arst_n,
  msplc_sub_if.filt sub
);
  import msplc_pkg::*;

  logic                sync1_r;
  logic                sync2_r;
  logic [4:0]          div_r;
  logic                tick;
  logic [FILT_LEN-1:0] samp_r;
  logic                subclk_r;
  logic [5:0]          gap_r;
  logic                selHeld_r;

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= sub.extPin;
      sync2_r <= sync1_r;
    end
  end

  // ************************************************************
  // Sampling clock divider
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end

  // Divide by 4 or by 32
  assign tick = sub.sampleSel ?
                (div_r[1:0] == `MSPLC_DIV_FAST) :
                (div_r == `MSPLC_DIV_SLOW);

  // ************************************************************
  // Noise filter
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      samp_r   <= '0;
      subclk_r <= 1'b0;
    end else if (!sub.inputEn) begin
      samp_r   <= '0;
      subclk_r <= 1'b0;
    end else if (tick) begin
      samp_r <= {samp_r[FILT_LEN-2:0], sync2_r};
      if (&{samp_r[FILT_LEN-2:0], sync2_r}) begin
        subclk_r <= 1'b1;
      end else if (~|{samp_r[FILT_LEN-2:0], sync2_r}) begin
        subclk_r <= 1'b0;
      end
    end
  end

  assign sub.subclk = subclk_r;

  // ************************************************************
  // Checks
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r     <= 6'h00;
      selHeld_r <= 1'b0;
    end else if (tick) begin
      gap_r     <= 6'h00;
      selHeld_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 6'h01;
      if ($changed(sub.sampleSel)) begin
        selHeld_r <= 1'b0;
      end
    end
  end

  sample_rate_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    (tick && selHeld_r && $stable(sub.sampleSel)) |->
      (gap_r == (sub.sampleSel ? 6'd3 : 6'd31)))
    else $error("subclock sampling period wrong");

  input_block_a : assert property (
    @(posedge mclk) disable iff (!arst_n)
    !sub.inputEn |=> !subclk_r)
    else $error("subclock passed while input disabled");

endmodule

`default_nettype wire

// ===== test/msplc_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none

module msplc_ctrl_test;
  import msplc_pkg::*;
  logic mclk = 1'b0, arst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  msplc_adr_t adr = 8'h00;
  logic [3:0] sel = 4'h0;
  msplc_word_t datI = 32'h0, datO;
  logic ack, pin, subOut, clrCnt = 1'b0;
  logic [7:0] halfPer = 8'h10;
  logic [15:0] edgeCnt;
  wire [12:0] stopVec;
  msplc_byte_t shH = 8'h3f, shL = 8'hff, shA = 8'h00, rd;
  int n_mismatch = 0, checks = 0;

  always #4 mclk = ~mclk;

  msplc_ctrl i_msplc_ctrl (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .extSubclkPin(pin),
    .subclkOut(subOut), .xferCtrlStop(stopVec[12]),
    .freeRunTimerStop(stopVec[11]), .timer8aStop(stopVec[10]),
    .pwmCh0Stop(stopVec[9]), .pwmCh1Stop(stopVec[8]), .adcStop(stopVec[7]),
    .timer8bStop(stopVec[6]), .serialIface3Stop(stopVec[5]),
    .serialIface1Stop(stopVec[4]), .twoWireCh0Stop(stopVec[3]),
    .twoWireCh1Stop(stopVec[2]), .twoWireCh23Stop(stopVec[1]),
    .crcStop(stopVec[0]));

  msplc_periph_model i_msplc_periph_model (.mclk(mclk), .arst_n(arst_n),
    .halfPer(halfPer), .clrCnt(clrCnt), .subclk(subOut), .extPin(pin),
    .edgeCnt(edgeCnt));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [12:0] expStops(msplc_byte_t h, l, a);
    return {h[6], h[5], h[4], h[3] | a[1], h[3] | a[2], h[1], h[0],
            l[7], l[6], l[4], l[3], l[2], l[1]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wb_xfer(input msplc_adr_t a, input logic w, input logic [3:0] s,
                         input msplc_byte_t d, output msplc_byte_t q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s;
    datI <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1);
    chk("ack", 32'h1, {31'h0, ack});
    chk("ack latency", 32'h2, n);
    q = datO[7:0];
    chk("read upper", 32'h0, {8'h00, datO[31:8]});
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  // Write, check stop outputs one edge later, then read back
  task automatic wr_chk(input msplc_adr_t a, input logic [3:0] s, input msplc_byte_t d);
    logic [12:0] old;
    msplc_byte_t e;
    old = expStops(shH, shL, shA);
    if (s[0]) begin
      case (a)
        8'h04: shH = d;
        8'h08: shL = d;
        8'h0c: shA = d;
        default: ;
      endcase
    end
    wb_xfer(a, 1'b1, s, d, rd);
    #1 chk("stops at write edge", {19'h0, old}, {19'h0, stopVec});
    @(posedge mclk);
    #1 chk("stops next edge", {19'h0, expStops(shH, shL, shA)}, {19'h0, stopVec});
    e = (a == 8'h04) ? shH : (a == 8'h08) ? shL : (a == 8'h0c) ? shA : 8'h00;
    if (a == 8'h00) e = s[0] ? d : 8'h00;
    wb_xfer(a, 1'b0, 4'hf, 8'h00, rd);
    chk("read back", {24'h0, e}, {24'h0, rd});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    msplc_byte_t rv[4] = '{8'h00, 8'h3f, 8'hff, 8'h00};
    #1 chk("reset stops", {19'h0, expStops(8'h3f, 8'hff, 8'h00)}, {19'h0, stopVec});
    chk("reset subclk", 32'h0, {31'h0, subOut});
    for (int i = 0; i < 4; i++) begin
      wb_xfer(8'(i * 4), 1'b0, 4'hf, 8'h00, rd);
      chk("reset value", {24'h0, rv[i]}, {24'h0, rd});
    end
    $display("test reset done");
  endtask

  task automatic t_map();
    for (int i = 0; i < 8; i++) begin
      wr_chk(8'h04, 4'h1, ((8'h01 << i) & 8'h7b) | 8'h04);
      wr_chk(8'h08, 4'h1, ((8'h01 << i) & 8'hde) | 8'h21);
    end
    wr_chk(8'h08, 4'h0, 8'hff);
    wr_chk(8'h10, 4'h1, 8'hff);
    $display("test stop map done");
  endtask

  task automatic t_pwm();
    for (int k = 0; k < 8; k++) begin
      wr_chk(8'h04, 4'h1, 8'h04 | (8'(k[2]) << 3));
      wr_chk(8'h0c, 4'h1, {5'h00, k[1], k[0], 1'b0});
    end
    $display("test pwm done");
  endtask

  task automatic t_subclk();
    msplc_byte_t lp[5] = '{8'h20, 8'h30, 8'h10, 8'h10, 8'h10};
    logic [7:0] hp[5] = '{8'h10, 8'h10, 8'h10, 8'h40, 8'h80};
    int lo[5] = '{0, 120, 0, 0, 14};
    int hi[5] = '{0, 130, 0, 0, 17};
    for (int i = 0; i < 5; i++) begin
      wr_chk(8'h00, 4'h1, lp[i]);
      halfPer <= hp[i];
      repeat (300) @(posedge mclk);
      clrCnt <= 1'b1;
      @(posedge mclk);
      clrCnt <= 1'b0;
      repeat (2000) @(posedge mclk);
      #1 chk("subclk edges", 32'h1, {31'h0, edgeCnt >= lo[i] && edgeCnt <= hi[i]});
      if (!lp[i][4]) chk("subclk blocked", 32'h0, {31'h0, subOut});
    end
    $display("test subclock done");
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_map();
    t_pwm();
    t_subclk();
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
endmodule

`default_nettype wire

// ===== test/msplc_periph_model.sv
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Far side: subclock pin source and filtered-clock edge counter
// ************************************************************
module msplc_periph_model (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  halfPer,
  input  wire logic        clrCnt,
  input  wire logic        subclk,
  output logic             extPin,
  output logic [15:0]      edgeCnt
);
  logic [7:0] phase_r;
  logic       pin_r;
  logic       prevSub_r;

  assign extPin = pin_r;

  // Pin toggles every halfPer clocks
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= 8'h00;
      pin_r   <= 1'b0;
    end else if (phase_r >= halfPer - 8'h01) begin
      phase_r <= 8'h00;
      pin_r   <= ~pin_r;
    end else begin
      phase_r <= phase_r + 8'h01;
    end
  end

  // Counts every change of the filtered subclock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prevSub_r <= 1'b0;
      edgeCnt   <= 16'h0000;
    end else begin
      prevSub_r <= subclk;
      if (clrCnt) begin
        edgeCnt <= 16'h0000;
      end else if (subclk != prevSub_r) begin
        edgeCnt <= edgeCnt + 16'h0001;
      end
    end
  end
endmodule

`default_nettype wire
